// [src/fwc_flash_ctrl.sv]
// flash write/erase sequencer with apb control registers
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module fwc_flash_ctrl
  import fwc_pkg::*;
#(
  parameter bit SMALL_DEVICE = 1'b0,
  parameter int ERASE_CYCLES = `FWC_ERASE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire fwc_req_t    xdm_req,
  output fwc_req_t         external_data_ram_req,
  input  wire logic        cmr_valid,
  input  wire logic        cmr_fetch,
  input  wire logic [15:0] cmr_addr,
  output logic      [7:0]  cmr_data,
  input  wire logic        jtag_req,
  input  wire fwc_jop_t    jtag_op,
  input  wire logic [15:0] jtag_addr,
  input  wire logic [7:0]  jtag_wdata,
  output logic      [7:0]  jtag_rdata,
  output logic             jtag_done,
  output logic             jtag_err,
  output logic             core_stall,
  output logic             irq_hold
);

  localparam logic [`FWC_CNT_W-1:0] WR_LAST = `FWC_CNT_W'(`FWC_WRITE_CYCLES - 1);
  localparam logic [`FWC_CNT_W-1:0] ER_LAST = `FWC_CNT_W'(ERASE_CYCLES - 1);
  localparam logic [15:0] RD_LOCK = SMALL_DEVICE ? `FWC_RD_LOCK_SMALL : `FWC_RD_LOCK_BIG; // RL18
  localparam logic [15:0] WR_LOCK = SMALL_DEVICE ? `FWC_WR_LOCK_SMALL : `FWC_WR_LOCK_BIG; // RL18
  localparam logic [15:0] RSV_BASE = SMALL_DEVICE ? `FWC_RSV_SMALL : `FWC_RSV_BIG;

  // ==========================================================
  // storage: main array plus double-mapped scratchpad
  logic [7:0] main_mem [0:65535];
  logic [7:0] scr_mem  [0:`FWC_SCR_BYTES-1];

  fwc_state_t s_reg;
  fwc_state_t s_next;

  function automatic logic is_reserved(input logic [15:0] a);
    is_reserved = (a >= RSV_BASE); // RL23
  endfunction

  function automatic logic in_lock_page(input logic [15:0] a);
    in_lock_page = (a[15:9] == WR_LOCK[15:9]);
  endfunction

  // one lock bit per 8k block; a zero bit locks the block
  function automatic logic block_open(input logic [7:0] lock, input logic [15:0] a);
    block_open = lock[a[15:13]]; // RL19 RL20
  endfunction

  // ==========================================================
  // request decode
  logic       busy;
  logic       sw_write;
  logic       sw_scr;
  logic       sw_ok;
  logic       sw_go;
  logic       jt_mod;
  logic       jt_ok;
  logic       jt_go;
  logic       commit_wr;
  logic       commit_er;
  logic [7:0] op_byte;
  logic       jt_rd_ok;

  assign busy      = (s_reg.st != S_IDLE);
  assign sw_write  = xdm_req.valid && xdm_req.write && s_reg.route_en; // RL7
  assign sw_scr    = s_reg.scr_sel && (xdm_req.addr < 16'(`FWC_SCR_BYTES)); // RL16
  // erase of the lock page by software is refused, byte writes pass
  assign sw_ok     = s_reg.permit && (sw_scr || (!is_reserved(xdm_req.addr)
                     && !(s_reg.erase_en && in_lock_page(xdm_req.addr)))); // RL11 RL21 RL23
  assign sw_go     = !busy && sw_write && sw_ok; // RL25
  assign jt_mod    = jtag_req && (jtag_op == FWC_JT_WRITE || jtag_op == FWC_JT_ERASE);
  assign jt_ok     = !is_reserved(jtag_addr) && block_open(main_mem[WR_LOCK], jtag_addr); // RL20 RL23
  // the core wins a same-cycle collision; the jtag request is dropped with no jtag_done
  assign jt_go     = !busy && jt_mod && jt_ok && !sw_write;
  assign jt_rd_ok  = (jtag_addr == RD_LOCK) || (jtag_addr == WR_LOCK)
                     || (!is_reserved(jtag_addr) && block_open(main_mem[RD_LOCK], jtag_addr)); // RL19
  assign commit_wr = (s_reg.st == S_WRITE) && (s_reg.cnt == '0);
  assign commit_er = (s_reg.st == S_ERASE) && (s_reg.cnt == '0);
  assign op_byte   = s_reg.scr ? scr_mem[s_reg.addr[6:0]] : main_mem[s_reg.addr];

  // ==========================================================
  // apb slave: zero wait states, error on unmapped offsets
  logic apb_wr;
  logic apb_hit;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_hit = (paddr == `FWC_ADDR_PSC) || (paddr == `FWC_ADDR_FCR) || (paddr == `FWC_ADDR_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `FWC_ADDR_PSC: begin
        prdata[`FWC_PSC_ROUTE_BIT] = s_reg.route_en;
        prdata[`FWC_PSC_ERASE_BIT] = s_reg.erase_en;
        prdata[`FWC_PSC_SCR_BIT]   = s_reg.scr_sel;
      end
      `FWC_ADDR_FCR:  prdata[`FWC_FCR_PERMIT_BIT] = s_reg.permit;
      `FWC_ADDR_STAT: begin
        prdata[`FWC_STAT_BUSY_BIT]  = busy;
        prdata[`FWC_STAT_ERASE_BIT] = (s_reg.st == S_ERASE);
        prdata[`FWC_STAT_REF_BIT]   = s_reg.refused;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.jtag_done = 1'b0;
    s_next.jtag_err  = 1'b0;
    s_next.external_data_ram      = '0;
    if (apb_wr && paddr == `FWC_ADDR_PSC) begin
      s_next.route_en = pwdata[`FWC_PSC_ROUTE_BIT]; // RL8
      s_next.erase_en = pwdata[`FWC_PSC_ERASE_BIT];
      s_next.scr_sel  = pwdata[`FWC_PSC_SCR_BIT];
    end
    if (apb_wr && paddr == `FWC_ADDR_FCR) begin
      s_next.permit = pwdata[`FWC_FCR_PERMIT_BIT]; // RL11
    end
    if (apb_wr && paddr == `FWC_ADDR_STAT && pwdata[`FWC_STAT_REF_BIT]) begin
      s_next.refused = 1'b0;
    end
    // the core sees no answer while stalled, so requests only count when idle
    if (!busy && xdm_req.valid && !sw_write) begin
      s_next.external_data_ram = xdm_req; // RL9
    end
    if (!busy && sw_write && !sw_ok) begin
      s_next.refused = 1'b1; // RL25
    end
    if (cmr_valid) begin
      // fetches always see main flash; reserved area reads as zero
      if (!cmr_fetch && s_reg.scr_sel && cmr_addr < 16'(`FWC_SCR_BYTES)) begin
        s_next.cmr_data = scr_mem[cmr_addr[6:0]]; // RL10 RL16 RL17
      end else if (is_reserved(cmr_addr)) begin
        s_next.cmr_data = 8'h00; // RL23
      end else begin
        s_next.cmr_data = main_mem[cmr_addr]; // RL10
      end
    end
    if (!busy && jtag_req && jtag_op == FWC_JT_READ && !sw_write) begin
      s_next.jtag_rdata = jt_rd_ok ? main_mem[jtag_addr] : 8'h00; // RL22
      s_next.jtag_err   = !jt_rd_ok;
      s_next.jtag_done  = 1'b1;
    end
    if (!busy && jt_mod && !jt_ok && !sw_write) begin
      s_next.jtag_err  = 1'b1; // RL20
      s_next.jtag_done = 1'b1;
    end
    unique case (s_reg.st)
      S_IDLE: begin
        if (sw_go) begin
          s_next.addr      = xdm_req.addr;
          s_next.data      = xdm_req.data;
          s_next.scr       = sw_scr;
          s_next.from_jtag = 1'b0;
          s_next.st        = s_reg.erase_en ? S_ERASE : S_WRITE; // RL12 RL13
          s_next.cnt       = s_reg.erase_en ? ER_LAST : WR_LAST; // RL24
        end else if (jt_go) begin
          s_next.addr      = jtag_addr;
          s_next.data      = jtag_wdata;
          s_next.scr       = 1'b0;
          s_next.from_jtag = 1'b1;
          s_next.st        = (jtag_op == FWC_JT_ERASE) ? S_ERASE : S_WRITE; // RL1
          s_next.cnt       = (jtag_op == FWC_JT_ERASE) ? ER_LAST : WR_LAST;
        end
      end
      S_WRITE, S_ERASE: begin
        if (s_reg.cnt == '0) begin
          s_next.st        = S_IDLE; // RL4
          s_next.jtag_done = s_reg.from_jtag;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // array update at the end of the timed operation
  always_ff @(posedge pclk) begin
    if (commit_wr) begin
      if (s_reg.scr) begin
        scr_mem[s_reg.addr[6:0]] <= scr_mem[s_reg.addr[6:0]] & s_reg.data; // RL2
      end else begin
        main_mem[s_reg.addr] <= main_mem[s_reg.addr] & s_reg.data; // RL2
      end
    end
    if (commit_er) begin
      if (s_reg.scr) begin
        for (int i = 0; i < `FWC_SCR_BYTES; i++) begin
          scr_mem[i] <= `FWC_ERASED;
        end
      end else begin
        for (int i = 0; i < `FWC_PAGE_BYTES; i++) begin
          main_mem[{s_reg.addr[15:9], 9'(i)}] <= `FWC_ERASED; // RL3
        end
      end
    end
  end

  assign external_data_ram_req   = s_reg.external_data_ram;
  assign cmr_data   = s_reg.cmr_data;
  assign jtag_rdata = s_reg.jtag_rdata;
  assign jtag_done  = s_reg.jtag_done;
  assign jtag_err   = s_reg.jtag_err;
  assign core_stall = busy; // RL5
  // the interrupt controller keeps requests pending while this is high
  assign irq_hold   = busy; // RL6

  // ==========================================================
  // checks
  logic [`FWC_CNT_W-1:0] stall_len;
  logic                  last_erase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_len  <= '0;
      last_erase <= 1'b0;
    end else begin
      stall_len  <= core_stall ? stall_len + 1'b1 : '0;
      last_erase <= busy ? (s_reg.st == S_ERASE) : last_erase;
    end
  end

  a_write_time: assert property (@(posedge pclk) disable iff (!presetn) // RL4 RL24
    $fell(core_stall) && !last_erase |-> stall_len == `FWC_CNT_W'(`FWC_WRITE_CYCLES))
    else $error("byte write stall length wrong");
  a_erase_time: assert property (@(posedge pclk) disable iff (!presetn) // RL24
    $fell(core_stall) && last_erase |-> stall_len == `FWC_CNT_W'(ERASE_CYCLES))
    else $error("page erase stall length wrong");
  a_and_write: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    commit_wr |=> op_byte == ($past(op_byte) & $past(s_reg.data)))
    else $error("byte write did not store old AND new");
  a_erase_fill: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    commit_er |=> op_byte == `FWC_ERASED)
    else $error("erased byte not 0xFF");
  a_no_permit: assert property (@(posedge pclk) disable iff (!presetn) // RL25 RL11
    !busy && sw_write && !s_reg.permit |=> !core_stall && s_reg.refused)
    else $error("write without permit was not ignored");
  a_read_to_ram: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    !busy && xdm_req.valid && !xdm_req.write |=> external_data_ram_req.valid && !external_data_ram_req.write)
    else $error("data-move read not sent to external ram");
  a_route_flash: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    !busy && sw_write |=> !external_data_ram_req.valid)
    else $error("routed write leaked to external ram");
  a_lock_erase: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    !busy && sw_write && s_reg.erase_en && !sw_scr && in_lock_page(xdm_req.addr) |=> !busy)
    else $error("software erased the lock page");
  a_route_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    $fell(s_reg.route_en) |-> $past(apb_wr && paddr == `FWC_ADDR_PSC))
    else $error("route enable cleared without software");
  a_jtag_locked: assert property (@(posedge pclk) disable iff (!presetn) // RL19 RL22
    !busy && !sw_write && jtag_req && jtag_op == FWC_JT_READ && !jt_rd_ok |=> jtag_err && jtag_done)
    else $error("locked jtag read not refused");
  a_stall_start: assert property (@(posedge pclk) disable iff (!presetn) // RL5 RL6
    sw_go |=> core_stall && irq_hold)
    else $error("permitted routed write did not stall the core");
  a_soft_permit: assert property (@(posedge pclk) disable iff (!presetn) // RL11 RL7
    $rose(core_stall) && !s_reg.from_jtag |-> $past(s_reg.permit) && $past(s_reg.route_en))
    else $error("software operation started without permit or routing");
  a_erase_choice: assert property (@(posedge pclk) disable iff (!presetn) // RL12 RL13
    sw_go |=> (s_reg.st == S_ERASE) == $past(s_reg.erase_en))
    else $error("erase enable did not pick the operation");
  a_no_reserved: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    busy |-> s_reg.scr || !is_reserved(s_reg.addr))
    else $error("operation running on the reserved area");
  a_lock_kept: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    s_reg.st == S_ERASE && !s_reg.from_jtag |-> s_reg.scr || !in_lock_page(s_reg.addr))
    else $error("software erase running on the lock page");
  a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    cmr_valid && is_reserved(cmr_addr) |=> cmr_data == 8'h00)
    else $error("reserved area was readable");
  a_jtag_refuse: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    !busy && !sw_write && jt_mod && !jt_ok |=> jtag_err && jtag_done && !core_stall)
    else $error("locked jtag write or erase not refused");
  a_jtag_end: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    $fell(core_stall) && s_reg.from_jtag |-> jtag_done && !jtag_err)
    else $error("jtag operation end not reported");
  a_external_data_ram_copy: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    !busy && xdm_req.valid && !sw_write |=> external_data_ram_req.addr == $past(xdm_req.addr))
    else $error("external ram request address not passed through");

  c_sw_erase: cover property (@(posedge pclk) disable iff (!presetn) commit_er && !s_reg.from_jtag);
  c_sw_write: cover property (@(posedge pclk) disable iff (!presetn) commit_wr && !s_reg.scr);
  c_scr_write: cover property (@(posedge pclk) disable iff (!presetn) commit_wr && s_reg.scr);
  c_jtag_write: cover property (@(posedge pclk) disable iff (!presetn) commit_wr && s_reg.from_jtag);
  c_jtag_refused: cover property (@(posedge pclk) disable iff (!presetn) jtag_done && jtag_err);

endmodule // fwc_flash_ctrl

// [shared/fwc_cfg.svh]
// constants for the flash write/erase controller
// How it works
// RL1: one byte per program operation, core or jtag
// RL2: byte write stores old AND new value
// RL3: erase sets whole 512-byte page to 0xFF
// RL4: write and erase durations timed by hardware
// RL5: core stalled during write or erase
// RL6: interrupts held until operation finishes
// RL7: route enable sends data-move writes to flash
// RL8: route enable stays set until software clears
// RL9: data-move reads always go to external ram
// RL10: flash read through code memory reads
// RL11: software write/erase needs soft write permit
// RL12: erase enable plus routed write erases page
// RL13: erase disabled, routed write programs one byte
// RL14: software should mask interrupts while routing
// RL15: software should avoid the reserved area
// RL16: scratchpad sector selected by scratchpad select
// RL17: no instruction fetch from scratchpad
// RL18: lock bytes at fixed top-of-flash addresses
// RL19: read lock bit zero blocks jtag reads
// RL20: write lock bit zero blocks jtag write/erase
// RL21: lock page writable but not software erasable
// RL22: locked jtag read returns undefined data
// RL23: reserved area never read, written or erased
// RL24: stall about 12 ms erase, 50 us write
// RL25: write without permit ignored, no stall
`ifndef FWC_CFG_SVH
`define FWC_CFG_SVH

// ==========================================================
// register map
`define FWC_ADDR_PSC      12'h000
`define FWC_ADDR_FCR      12'h004
`define FWC_ADDR_STAT     12'h008
`define FWC_PSC_ROUTE_BIT 0
`define FWC_PSC_ERASE_BIT 1
`define FWC_PSC_SCR_BIT   2
`define FWC_FCR_PERMIT_BIT 0
`define FWC_STAT_BUSY_BIT  0
`define FWC_STAT_ERASE_BIT 1
`define FWC_STAT_REF_BIT   2

// ==========================================================
// flash geometry
`define FWC_PAGE_BYTES    512
`define FWC_SCR_BYTES     128
`define FWC_ERASED        8'hFF
`define FWC_RD_LOCK_BIG   16'hFDFF
`define FWC_WR_LOCK_BIG   16'hFDFE
`define FWC_RD_LOCK_SMALL 16'h7FFF
`define FWC_WR_LOCK_SMALL 16'h7FFE
`define FWC_RSV_BIG       16'hFE00
`define FWC_RSV_SMALL     16'h8000

// ==========================================================
// timing
`define FWC_CLK_MHZ       50
`define FWC_WRITE_TIME_US 50
`define FWC_ERASE_TIME_MS 12
`define FWC_WRITE_CYCLES  (`FWC_WRITE_TIME_US * `FWC_CLK_MHZ)
`define FWC_ERASE_CYCLES  (`FWC_ERASE_TIME_MS * 1000 * `FWC_CLK_MHZ)
`define FWC_CNT_W         20

`endif

// [shared/fwc_pkg.sv]
// types of the flash write/erase controller
`include "fwc_cfg.svh"
package fwc_pkg;

  typedef enum logic [1:0] {FWC_JT_READ, FWC_JT_WRITE, FWC_JT_ERASE, FWC_JT_NONE} fwc_jop_t;

  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_ERASE} fwc_fsm_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } fwc_req_t;

  typedef struct packed {
    fwc_fsm_t              st;
    logic                  route_en;
    logic                  erase_en;
    logic                  scr_sel;
    logic                  permit;
    logic                  refused;
    logic [`FWC_CNT_W-1:0] cnt;
    logic [15:0]           addr;
    logic [7:0]            data;
    logic                  scr;
    logic                  from_jtag;
    fwc_req_t              external_data_ram;
    logic [7:0]            cmr_data;
    logic [7:0]            jtag_rdata;
    logic                  jtag_done;
    logic                  jtag_err;
  } fwc_state_t;

endpackage

// [dv/fwc_core_model.sv]
// core-side partner that issues external data moves and honours the stall
`timescale 1ns/1ps
module fwc_core_model
  import fwc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic core_stall,
  output fwc_req_t  xdm_req
);
  initial xdm_req = '0;

  // a stalled core cannot issue, so a new move waits for the stall to drop
  task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    while (core_stall !== 1'b0) @(posedge pclk);
    xdm_req <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge pclk);
    // released fields show the inverse so stale values are never trusted
    xdm_req <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
  endtask
endmodule // fwc_core_model

// [dv/testbench.sv]
// self-checking bench for the flash write/erase controller
`timescale 1ns/1ps
`include "fwc_cfg.svh"
module testbench
  import fwc_pkg::*;
;
  localparam int          ERASE_N = 20;
  localparam int          WRITE_N = `FWC_WRITE_CYCLES;
  localparam logic [31:0] ROUTE   = 32'h1 << `FWC_PSC_ROUTE_BIT;
  localparam logic [31:0] ERASE   = 32'h1 << `FWC_PSC_ERASE_BIT;
  localparam logic [31:0] SCR     = 32'h1 << `FWC_PSC_SCR_BIT;
  localparam logic [31:0] REFUSED = 32'h1 << `FWC_STAT_REF_BIT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  fwc_req_t    xdm_req, external_data_ram_req;
  logic        cmr_valid, cmr_fetch, jtag_req, jtag_done, jtag_err, core_stall, irq_hold;
  logic [15:0] cmr_addr, jtag_addr;
  logic [7:0]  cmr_data, jtag_wdata, jtag_rdata;
  fwc_jop_t    jtag_op;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  logic        irq, e;
  logic [31:0] r;
  logic [7:0]  b;

  fwc_flash_ctrl #(.SMALL_DEVICE(1'b0), .ERASE_CYCLES(ERASE_N)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xdm_req(xdm_req), .external_data_ram_req(external_data_ram_req), .cmr_valid(cmr_valid), .cmr_fetch(cmr_fetch),
    .cmr_addr(cmr_addr), .cmr_data(cmr_data), .jtag_req(jtag_req), .jtag_op(jtag_op),
    .jtag_addr(jtag_addr), .jtag_wdata(jtag_wdata), .jtag_rdata(jtag_rdata),
    .jtag_done(jtag_done), .jtag_err(jtag_err), .core_stall(core_stall), .irq_hold(irq_hold));
  fwc_core_model core (.pclk(pclk), .core_stall(core_stall), .xdm_req(xdm_req));

  // ==========================================================
  // shared tasks
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // the model core raises no interrupts, so nothing needs masking while routing is on
  task automatic psc(logic [31:0] v);
    apb(1'b1, `FWC_ADDR_PSC, v, r, e);
  endtask

  // stall length counted as cycles with the stall high
  task automatic move_n(logic w, logic [15:0] a, logic [7:0] d);
    core.move(w, a, d);
    n = 0;
    repeat (3) begin
      #1;
      if (core_stall === 1'b1) break;
      @(posedge pclk);
    end
    irq = irq_hold;
    while (core_stall === 1'b1) begin
      n++;
      @(posedge pclk);
      #1;
    end
  endtask

  task automatic code_rd(logic f, logic [15:0] a);
    @(posedge pclk);
    cmr_valid <= 1'b1;
    cmr_fetch <= f;
    cmr_addr  <= a;
    @(posedge pclk);
    cmr_valid <= 1'b0;
    #1 b = cmr_data;
  endtask

  task automatic jtag(fwc_jop_t op, logic [15:0] a, logic [7:0] d);
    @(posedge pclk);
    jtag_req   <= 1'b1;
    jtag_op    <= op;
    jtag_addr  <= a;
    jtag_wdata <= d;
    @(posedge pclk);
    jtag_req   <= 1'b0;
    #1;
    while (jtag_done !== 1'b1) begin
      @(posedge pclk);
      #1;
    end
    e = jtag_err;
    b = jtag_rdata;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    apb(1'b0, `FWC_ADDR_PSC, 32'h0, r, e);
    check("psc reset", r, 32'h0);
    apb(1'b0, `FWC_ADDR_FCR, 32'h0, r, e);
    check("fcr reset", r, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    check("unmapped err", {31'h0, e}, 32'h1);
  endtask

  task automatic t_no_permit();
    psc(ROUTE);
    move_n(1'b1, 16'h1000, 8'h00);
    check("no permit stall", n, 0);
    apb(1'b0, `FWC_ADDR_STAT, 32'h0, r, e);
    check("refused flag", r, REFUSED);
    apb(1'b1, `FWC_ADDR_STAT, REFUSED, r, e);
    apb(1'b0, `FWC_ADDR_STAT, 32'h0, r, e);
    check("refused cleared", r, 32'h0);
  endtask

  task automatic t_erase_write();
    apb(1'b1, `FWC_ADDR_FCR, 32'h1, r, e);
    psc(ROUTE | ERASE);
    move_n(1'b1, 16'h1234, 8'h00);
    check("erase stall", n, ERASE_N);
    check("irq held", irq, 1'b1);
    code_rd(1'b0, 16'h1200);
    check("page first", b, 8'hFF);
    code_rd(1'b1, 16'h13FF);
    check("page last", b, 8'hFF);
    psc(ROUTE);
    move_n(1'b1, 16'h1201, 8'h5A);
    check("write stall", n, WRITE_N);
    move_n(1'b1, 16'h1201, 8'hF0);
    code_rd(1'b0, 16'h1201);
    check("and store", b, 8'h50);
    apb(1'b0, `FWC_ADDR_PSC, 32'h0, r, e);
    check("route kept", r, ROUTE);
  endtask

  task automatic t_external_data_ram();
    psc(32'h0);
    core.move(1'b1, 16'h2000, 8'h3C);
    #1 check("external_data_ram write", {external_data_ram_req.valid, external_data_ram_req.write, external_data_ram_req.addr, external_data_ram_req.data}, 26'h3_2000_3C);
    psc(ROUTE);
    core.move(1'b0, 16'h2001, 8'h00);
    #1 check("external_data_ram read", {external_data_ram_req.valid, external_data_ram_req.write, external_data_ram_req.addr}, 18'h2_2001);
    check("no stall", core_stall, 1'b0);
  endtask

  task automatic t_protect();
    psc(ROUTE | ERASE);
    move_n(1'b1, 16'hFC10, 8'h00);
    check("lock page erase", n, 0);
    move_n(1'b1, 16'hFE10, 8'h00);
    check("reserved erase", n, 0);
    psc(ROUTE);
    move_n(1'b1, `FWC_WR_LOCK_BIG, 8'h00);
    check("lock byte write", n, WRITE_N);
    move_n(1'b1, `FWC_RD_LOCK_BIG, 8'h00);
    code_rd(1'b0, 16'hFE10);
    check("reserved read", b, 8'h00);
  endtask

  task automatic t_scratch();
    psc(ROUTE | ERASE);
    move_n(1'b1, 16'h0000, 8'h00);
    psc(ROUTE | ERASE | SCR);
    move_n(1'b1, 16'h0010, 8'h00);
    check("scratch erase", n, ERASE_N);
    psc(ROUTE | SCR);
    move_n(1'b1, 16'h0010, 8'h12);
    code_rd(1'b0, 16'h0010);
    check("scratch read", b, 8'h12);
    code_rd(1'b1, 16'h0010);
    check("fetch main", b, 8'hFF);
    psc(32'h0);
    code_rd(1'b0, 16'h0010);
    check("main read", b, 8'hFF);
  endtask

  task automatic t_jtag();
    jtag(FWC_JT_WRITE, 16'h1202, 8'h00);
    check("jtag write lock", e, 1'b1);
    jtag(FWC_JT_READ, 16'h1200, 8'h00);
    check("jtag read lock", {b, 7'h0, e}, 16'h0001);
    jtag(FWC_JT_READ, `FWC_RD_LOCK_BIG, 8'h00);
    check("lock byte read", {b, 7'h0, e}, 16'h0000);
  endtask

  // ==========================================================
  // run control
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // five byte writes of 2500 cycles each dominate the run time
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, cmr_valid, cmr_fetch, jtag_req} = '0;
    {paddr, pwdata, cmr_addr, jtag_addr, jtag_wdata} = '0;
    jtag_op = FWC_JT_NONE;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_no_permit();
    t_erase_write();
    t_external_data_ram();
    t_protect();
    t_scratch();
    t_jtag();
    report_and_stop();
  end
endmodule // testbench
